// *** common/pd_defs.vh ***
// constants for the power-down entry and exit controller
`ifndef SLEEP_DEFS_VH
`define SLEEP_DEFS_VH

// register indices and byte addresses (address is four times the index)
`define PWR_INDEX         8'h87
`define WAKE_CFG_INDEX    8'h88
`define SLEEP_STATUS_INDEX 8'h89
`define PWR_ADDR          12'h21C
`define WAKE_CFG_ADDR     12'h220
`define SLEEP_STATUS_ADDR 12'h224

// power control register fields
`define PWR_IDLE_BIT      0
`define PWR_SLEEP_BIT     1
`define PWR_FLAG0_BIT     2
`define PWR_FLAG1_BIT     3
`define PWR_RESET         4'h0

// wake configuration fields
`define WCFG_EN_A_BIT     0
`define WCFG_EN_B_BIT     1
`define WCFG_EXT_CODE_BIT 2
`define WCFG_RESET        3'h0

// timing
`define CLK_PERIOD_NS     40
`define OSC_STABLE_NS     2000
`define OSC_STABLE_CYC    ((`OSC_STABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_RUN_NS        400
`define RST_RUN_CYC       (`RST_RUN_NS / `CLK_PERIOD_NS)

// program start address after reset
`define RESET_VECTOR      16'h0000

`endif

// *** core/sync2.v ***
// two flip-flop synchroniser for asynchronous pin levels
module sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             sys_clk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            meta_r   <= INIT;
            sync_out <= INIT;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule // sync2

// *** core/cycle_timer.v ***
// loadable down counter that pulses done the cycle after it reaches one, load_val cycles after the load
module cycle_timer #(
    parameter WIDTH = 16
) (
    input  wire             sys_clk,
    input  wire             reset_n,
    input  wire             load,
    input  wire [WIDTH-1:0] load_val,
    output reg              done
);

    reg [WIDTH-1:0] count_r;
    reg             busy_r;

    // count down after a load, one-cycle done at the end
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            count_r <= {WIDTH{1'b0}};
            busy_r  <= 1'b0;
            done    <= 1'b0;
        end else if (load) begin
            count_r <= load_val;
            busy_r  <= 1'b1;
            done    <= 1'b0;
        end else if (busy_r) begin
            if (count_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                busy_r <= 1'b0;
                done   <= 1'b1;
            end else begin
                count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
                done    <= 1'b0;
            end
        end else begin
            done <= 1'b0;
        end
    end

endmodule // cycle_timer

// *** core/power_down_entry_exit_control.v ***
// power-down entry and exit controller with APB register access
// Overview of operation
// - writing the power-down request bit stops the cpu, the peripheral clocks and the oscillator in the same cycle.
// - either external interrupt line, when enabled, wakes the device from power-down.
// - an interrupt wake clears the request bit, starts the oscillator, then restores clocks.
// - after an interrupt wake the cpu waits for line release, then gets its interrupt.
// - an interrupt wake leaves the control register except the request bits, the wake configuration register and the internal ram untouched.
// - a high reset pin clears the request bit and restarts oscillator and clocks.
// - after a reset wake the cpu runs briefly, then reset restarts it at address 0000h.
// - during that brief run internal ram is blocked while port access stays allowed.
// - a reset wake restores the control and wake configuration registers to reset values and keeps internal ram.
// - pins follow the mode: port 0 floats in reset or external-code sleep, strobes per mode.
// - power-down wins when power-down and idle requests are set together.
// - the control register holds two flags, power-down and idle in its low four bits.
//
// Added by the designer: the APB register port and the register addresses.
`include "pd_defs.vh"

module power_down_entry_exit_control #(
    parameter OSC_CYCLES = `OSC_STABLE_CYC,
    parameter RST_CYCLES = `RST_RUN_CYC,
    parameter TW         = 16
) (
    input  wire        sys_clk,
    input  wire        reset_n,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // external pins, active low interrupts and active high reset
    input  wire        ext_irq_line_a_n,
    input  wire        ext_irq_line_b_n,
    input  wire        rst_pin,
    // normal pin values from the core
    input  wire [7:0]  core_port0_out,
    input  wire        core_port0_oe,
    input  wire [31:0] core_port14_out,
    input  wire        core_ale,
    input  wire        core_fetch_strobe_n,
    // pin drive
    output reg  [7:0]  port0_out,
    output reg         port0_oe,
    output reg  [31:0] port14_out,
    output reg         ale_out,
    output reg         program_fetch_strobe,
    // clock and cpu control
    output reg         osc_enable,
    output reg         cpu_clk_en,
    output reg         periph_clk_en,
    output reg         core_reset,
    output reg         ram_block,
    output reg         wake_irq_req,
    output reg  [1:0]  wake_irq_src,
    output wire [15:0] reset_vector,
    output reg         powerdown_active,
    output reg         idle_active
);

    localparam [2:0] ST_RUN      = 3'h0;
    localparam [2:0] ST_SLEEP    = 3'h1;
    localparam [2:0] ST_OSC_WAIT = 3'h2;
    localparam [2:0] ST_HOLD     = 3'h3;
    localparam [2:0] ST_RST_RUN  = 3'h4;
    localparam [2:0] ST_RST_HOLD = 3'h5;

    reg  [2:0] state_r;
    reg  [2:0] state_nxt;
    reg  [3:0] pwr_r;
    reg  [3:0] pwr_nxt;
    reg  [2:0] wcfg_r;
    reg  [1:0] cause_r;
    reg  [1:0] cause_nxt;
    reg        rst_cause_r;
    reg        rst_cause_nxt;
    reg        tmr_load;
    reg [TW-1:0] tmr_val;
    wire       tmr_done;
    wire [2:0] pin_s;
    wire       irq_a_s;
    wire       irq_b_s;
    wire       rst_s;
    wire [1:0] wake_hit;
    wire       wr_en;
    wire       rd_setup;
    reg        wr_sleep_set;

    // register address compare helper
    function addr_hit;
        input [11:0] a;
        input [11:0] b;
        begin
            addr_hit = (a == b);
        end
    endfunction

    // pins cross into the clock domain; lines idle high, reset pin idle low
    sync2 #(
        .WIDTH (3),
        .INIT  (3'b011)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({rst_pin, ext_irq_line_b_n, ext_irq_line_a_n}),
        .sync_out (pin_s)
    );

    assign irq_a_s = ~pin_s[0];
    assign irq_b_s = ~pin_s[1];
    assign rst_s   = pin_s[2];

    assign wake_hit = {irq_b_s & wcfg_r[`WCFG_EN_B_BIT],
                       irq_a_s & wcfg_r[`WCFG_EN_A_BIT]};

    // oscillator settle and brief post-reset run timing
    cycle_timer #(
        .WIDTH (TW)
    ) u_timer (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // apb handshake: zero wait states
    assign pready       = 1'b1;
    assign wr_en        = psel & penable & pwrite;
    assign rd_setup     = psel & ~penable & ~pwrite;
    assign reset_vector = `RESET_VECTOR;

    // state and wake bookkeeping
    always @* begin
        state_nxt     = state_r;
        cause_nxt     = cause_r;
        rst_cause_nxt = rst_cause_r;
        tmr_load      = 1'b0;
        tmr_val       = {TW{1'b0}};
        wr_sleep_set  = wr_en & addr_hit(paddr, `PWR_ADDR) & pwdata[`PWR_SLEEP_BIT];
        case (state_r)
            ST_RUN: begin
                if (rst_s) begin
                    state_nxt = ST_RST_HOLD;
                // stop right after the setting write
                end else if (pwr_r[`PWR_SLEEP_BIT]) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (rst_s) begin
                    state_nxt     = ST_RST_RUN;
                    rst_cause_nxt = 1'b1;
                    tmr_load      = 1'b1;
                    tmr_val       = RST_CYCLES[TW-1:0];
                end else if (|wake_hit) begin
                    state_nxt     = ST_OSC_WAIT;
                    cause_nxt     = wake_hit;
                    rst_cause_nxt = 1'b0;
                    tmr_load      = 1'b1;
                    tmr_val       = OSC_CYCLES[TW-1:0];
                end
            end
            ST_OSC_WAIT: begin
                if (rst_s) begin
                    state_nxt = ST_RST_HOLD;
                end else if (tmr_done) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (rst_s) begin
                    state_nxt = ST_RST_HOLD;
                // resume once the waking line is released
                end else if (!(|(cause_r & {irq_b_s, irq_a_s}))) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RST_RUN: begin
                // brief run, then internal reset takes over
                if (tmr_done) begin
                    state_nxt = ST_RST_HOLD;
                end
            end
            ST_RST_HOLD: begin
                if (!rst_s) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // power control register next value
    always @* begin
        pwr_nxt = pwr_r;
        if (wr_en && addr_hit(paddr, `PWR_ADDR)) begin
            pwr_nxt = pwdata[3:0];
        end
        // hardware clears the request bits on interrupt wake
        if (state_r == ST_SLEEP && !rst_s && |wake_hit) begin
            pwr_nxt[`PWR_SLEEP_BIT] = 1'b0;
            pwr_nxt[`PWR_IDLE_BIT]  = 1'b0;
        end
        // reset pin clears the power-down bit
        if (rst_s) begin
            pwr_nxt[`PWR_SLEEP_BIT] = 1'b0;
            pwr_nxt[`PWR_IDLE_BIT]  = 1'b0;
        end
        // software setting wins over a same-cycle interrupt-wake clear, not over the reset pin
        if (wr_sleep_set && !rst_s) begin
            pwr_nxt[`PWR_SLEEP_BIT] = 1'b1;
        end
        if (state_r == ST_RST_HOLD) begin
            pwr_nxt = `PWR_RESET;
        end
    end

    // registers and state
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            state_r     <= ST_RUN;
            pwr_r       <= `PWR_RESET;
            wcfg_r      <= `WCFG_RESET;
            cause_r     <= 2'b00;
            rst_cause_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            pwr_r       <= pwr_nxt;
            cause_r     <= cause_nxt;
            rst_cause_r <= rst_cause_nxt;
            if (state_r == ST_RST_HOLD) begin
                wcfg_r <= `WCFG_RESET;
            end else if (wr_en && addr_hit(paddr, `WAKE_CFG_ADDR)) begin
                wcfg_r <= pwdata[2:0];
            end
        end
    end

    // apb read data captured in the setup phase
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (rd_setup || (psel && !penable)) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            // low four bits hold flags, upper bits read zero
            if (addr_hit(paddr, `PWR_ADDR)) begin
                prdata <= {28'h0, pwr_r};
            end else if (addr_hit(paddr, `WAKE_CFG_ADDR)) begin
                prdata <= {29'h0, wcfg_r};
            end else if (addr_hit(paddr, `SLEEP_STATUS_ADDR)) begin
                prdata <= {22'h0, pin_s, rst_cause_r, cause_r, 1'b0, state_r};
            end else begin
                pslverr <= 1'b1;
            end
        end
    end

    // clock, reset and ram control outputs
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            osc_enable       <= 1'b1;
            cpu_clk_en       <= 1'b1;
            periph_clk_en    <= 1'b1;
            core_reset       <= 1'b0;
            ram_block        <= 1'b0;
            wake_irq_req     <= 1'b0;
            wake_irq_src     <= 2'b00;
            powerdown_active <= 1'b0;
            idle_active      <= 1'b0;
        end else begin
            // freeze clocks in the cycle the request bit is set
            osc_enable       <= (state_nxt != ST_SLEEP) && !pwr_nxt[`PWR_SLEEP_BIT];
            powerdown_active <= (state_nxt == ST_SLEEP) || pwr_nxt[`PWR_SLEEP_BIT];
            idle_active      <= pwr_nxt[`PWR_IDLE_BIT] && !pwr_nxt[`PWR_SLEEP_BIT];
            // clocks return after oscillator settle on interrupt wake, at once on reset wake
            periph_clk_en    <= (state_nxt == ST_RUN || state_nxt == ST_HOLD ||
                                 state_nxt == ST_RST_RUN || state_nxt == ST_RST_HOLD) &&
                                !pwr_nxt[`PWR_SLEEP_BIT];
            // cpu held until the line is released
            cpu_clk_en       <= (state_nxt == ST_RUN || state_nxt == ST_RST_RUN ||
                                 state_nxt == ST_RST_HOLD) && !pwr_nxt[`PWR_SLEEP_BIT] &&
                                !pwr_nxt[`PWR_IDLE_BIT];
            // reset vectors the cpu once the brief run ends
            core_reset       <= (state_nxt == ST_RST_HOLD);
            // internal ram blocked during the brief run
            ram_block        <= (state_nxt == ST_RST_RUN);
            // interrupt request pulses when execution resumes
            // interrupt wake raises no register reset
            wake_irq_req     <= (state_r == ST_HOLD) && (state_nxt == ST_RUN);
            if ((state_r == ST_HOLD) && (state_nxt == ST_RUN)) begin
                wake_irq_src <= cause_r;
            end
        end
    end

    // pin states by mode
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            port0_out            <= 8'h00;
            port0_oe             <= 1'b0;
            port14_out           <= 32'hFFFFFFFF;
            ale_out              <= 1'b1;
            program_fetch_strobe <= 1'b1;
        end else if (state_nxt == ST_RST_HOLD) begin
            // reset floats port 0, drives the rest high
            port0_out            <= 8'h00;
            port0_oe             <= 1'b0;
            port14_out           <= 32'hFFFFFFFF;
            ale_out              <= 1'b1;
            program_fetch_strobe <= 1'b1;
        end else if (state_nxt == ST_SLEEP || state_nxt == ST_OSC_WAIT ||
                     pwr_nxt[`PWR_SLEEP_BIT]) begin
            // power-down drives both strobes low, ports keep data
            port0_out            <= core_port0_out;
            port0_oe             <= core_port0_oe & ~wcfg_r[`WCFG_EXT_CODE_BIT];
            port14_out           <= core_port14_out;
            ale_out              <= 1'b0;
            program_fetch_strobe <= 1'b0;
        end else if (pwr_nxt[`PWR_IDLE_BIT]) begin
            port0_out            <= core_port0_out;
            port0_oe             <= core_port0_oe & ~wcfg_r[`WCFG_EXT_CODE_BIT];
            port14_out           <= core_port14_out;
            ale_out              <= 1'b1;
            program_fetch_strobe <= 1'b1;
        end else begin
            port0_out            <= core_port0_out;
            port0_oe             <= core_port0_oe;
            port14_out           <= core_port14_out;
            ale_out              <= core_ale;
            program_fetch_strobe <= core_fetch_strobe_n;
        end
    end

endmodule // power_down_entry_exit_control

// *** test/sleep_chk.sv ***
// port-level assertions for the power-down entry and exit controller
module sleep_chk (
    input wire        sys_clk,
    input wire        reset_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        ext_irq_line_a_n,
    input wire        ext_irq_line_b_n,
    input wire        ale_out,
    input wire        program_fetch_strobe,
    input wire        osc_enable,
    input wire        cpu_clk_en,
    input wire        periph_clk_en,
    input wire        core_reset,
    input wire        ram_block,
    input wire        wake_irq_req,
    input wire [1:0]  wake_irq_src,
    input wire [15:0] reset_vector,
    input wire        powerdown_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // a completed bus write that sets the sleep request
    wire sleep_wr = psel && penable && pwrite && paddr == 12'h21C && pwdata[1];

    // entry and wake ordering
    entry_stop_a: assert property (sleep_wr && !powerdown_active && !core_reset
        |=> !osc_enable && !cpu_clk_en && !periph_clk_en && powerdown_active)
        else $error("clocks still running after sleep request");
    osc_first_a: assert property ($rose(periph_clk_en) && !cpu_clk_en
        |-> $past(osc_enable, 2)) else $error("peripheral clock before oscillator");
    cpu_last_a: assert property ($rose(cpu_clk_en) |-> osc_enable && periph_clk_en)
        else $error("cpu clock before oscillator and peripherals");
    hold_release_a: assert property ($rose(cpu_clk_en) && !ram_block
        |-> $past(ext_irq_line_a_n, 2) && $past(ext_irq_line_b_n, 2))
        else $error("cpu resumed while wake line still low");
    irq_pulse_a: assert property (wake_irq_req |=> !wake_irq_req)
        else $error("wake interrupt longer than one cycle");
    irq_clocked_a: assert property (wake_irq_req
        |-> cpu_clk_en && !core_reset && wake_irq_src != 2'h0)
        else $error("wake interrupt without clock or cause");
    // pins and reset wake
    sleep_strobes_a: assert property (powerdown_active
        |-> !ale_out && !program_fetch_strobe) else $error("strobes high while asleep");
    reset_clocks_a: assert property (ram_block
        |-> osc_enable && cpu_clk_en && periph_clk_en) else $error("clocks off in reset run");
    ram_handover_a: assert property ($fell(ram_block) |-> core_reset)
        else $error("ram unblocked without core reset");
    start_vector_a: assert property (core_reset |-> reset_vector == 16'h0000)
        else $error("restart address not zero");
endmodule // sleep_chk

// *** test/wake_pins_model.sv ***
// model of the wake sources: two interrupt lines and the reset pin
module wake_pins_model (
    input  wire  sys_clk,
    output logic ext_irq_line_a_n,
    output logic ext_irq_line_b_n,
    output logic rst_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // lines idle at their pull levels
    initial begin
        ext_irq_line_a_n = 1'b1;
        ext_irq_line_b_n = 1'b1;
        rst_pin = 1'b0;
    end

    // level held long
    // pin 0 line a, 1 line b, 2 reset; held for hold cycles then released
    task pulse(input int pin, input int hold);
        @(posedge sys_clk);
        if (pin == 0) ext_irq_line_a_n <= 1'b0;
        else if (pin == 1) ext_irq_line_b_n <= 1'b0;
        else rst_pin <= 1'b1;
        repeat (hold) @(posedge sys_clk);
        ext_irq_line_a_n <= 1'b1;
        ext_irq_line_b_n <= 1'b1;
        rst_pin <= 1'b0;
    endtask
endmodule // wake_pins_model

// *** test/power_down_entry_exit_control_tb_top.sv ***
// self-checking bench for the power-down entry and exit controller
module power_down_entry_exit_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [11:0] CTRL = 12'h21C;
    localparam [11:0] CFG  = 12'h220;
    localparam [11:0] STAT = 12'h224;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0]  core_port0_out = 8'h5A;
    logic        core_port0_oe = 1'b1;
    logic [31:0] core_port14_out = 32'h12345678;
    logic        core_ale = 1'b0;
    logic        core_fetch_strobe_n = 1'b0;
    wire         pready, pslverr, port0_oe, ale_out, program_fetch_strobe;
    wire         osc_enable, cpu_clk_en, periph_clk_en, core_reset, ram_block;
    wire         wake_irq_req, powerdown_active, idle_active, rst_pin;
    wire         ext_irq_line_a_n, ext_irq_line_b_n;
    wire [31:0]  prdata, port14_out;
    wire [7:0]   port0_out;
    wire [15:0]  reset_vector;
    wire [1:0]   wake_irq_src;
    int          miscompares = 0;
    int          compares = 0;
    logic [31:0] rd;
    logic        er;
    wire [5:0]   mon = {ram_block, core_reset, wake_irq_req, periph_clk_en, osc_enable,
                        powerdown_active};

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    power_down_entry_exit_control #(.OSC_CYCLES(2), .RST_CYCLES(2)) u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .ext_irq_line_a_n(ext_irq_line_a_n),
        .ext_irq_line_b_n(ext_irq_line_b_n), .rst_pin(rst_pin),
        .core_port0_out(core_port0_out), .core_port0_oe(core_port0_oe),
        .core_port14_out(core_port14_out), .core_ale(core_ale),
        .core_fetch_strobe_n(core_fetch_strobe_n), .port0_out(port0_out), .port0_oe(port0_oe),
        .port14_out(port14_out), .ale_out(ale_out),
        .program_fetch_strobe(program_fetch_strobe), .osc_enable(osc_enable),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .core_reset(core_reset),
        .ram_block(ram_block), .wake_irq_req(wake_irq_req), .wake_irq_src(wake_irq_src),
        .reset_vector(reset_vector), .powerdown_active(powerdown_active),
        .idle_active(idle_active));

    wake_pins_model u_src (.sys_clk(sys_clk), .ext_irq_line_a_n(ext_irq_line_a_n),
        .ext_irq_line_b_n(ext_irq_line_b_n), .rst_pin(rst_pin));

    task stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input string nm, input [31:0] exp, input [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", nm, exp, got);
            miscompares++;
        end
    endtask

    // one apb transfer, held until pready is seen
    task apb(input logic w, input [11:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("BAD pready exp 1 got %b", pready);
            miscompares++;
            stop_test;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rc(input string nm, input [11:0] a, input [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(nm, exp, rd);
    endtask

    // bounded wait for one monitored flag
    task wt(input int k, input logic v);
        int n;
        n = 0;
        while (mon[k] !== v && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        if (mon[k] !== v) begin
            $display("BAD wait%0d exp %b got %b", k, v, mon[k]);
            miscompares++;
            stop_test;
        end
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rc("ctrl", CTRL, 32'h00000000);
        rc("cfg", CFG, 32'h00000000);
        rc("status", STAT, 32'h00000180);
        apb(1'b0, 12'h300, 32'h00000000);
        chk("err", 32'h00000001, er);
        apb(1'b1, CTRL, 32'hFFFFFFFC);
        rc("flags", CTRL, 32'h0000000C);
        chk("p0", 32'h0000005A, port0_out);
        chk("ale", 32'h00000000, ale_out);
        apb(1'b1, CTRL, 32'h00000001);
        @(posedge sys_clk);
        chk("idleon", 32'h00000001, idle_active);
        chk("idlestb", 32'h00000001, ale_out & program_fetch_strobe);
        chk("idlecpu", 32'h00000000, cpu_clk_en);
        apb(1'b1, CTRL, 32'h0000000C);
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, CFG, 1 << i);
            apb(1'b1, CTRL, 32'h0000000F);
            wt(0, 1'b1);
            chk("idle", 32'h00000000, idle_active);
            apb(1'b0, STAT, 32'h00000000);
            chk("state", 32'h00000001, rd[2:0]);
            chk("p0oe", 32'h00000001, port0_oe);
            chk("p14", 32'h12345678, port14_out);
            chk("p0pd", 32'h0000005A, port0_out);
            u_src.pulse(1 - i, 10);
            repeat (4) @(posedge sys_clk);
            chk("osc", 32'h00000000, osc_enable);
            fork
                u_src.pulse(i, 20);
                begin
                    wt(1, 1'b1);
                    chk("cpuoff", 32'h00000000, cpu_clk_en);
                    wt(2, 1'b1);
                    chk("cpuheld", 32'h00000000, cpu_clk_en);
                end
            join
            wt(3, 1'b1);
            chk("src", 1 << i, wake_irq_src);
            chk("corerst", 32'h00000000, core_reset);
            rc("ctrlkeep", CTRL, 32'h0000000C);
            rc("cfgkeep", CFG, 1 << i);
            chk("idle", 32'h00000000, idle_active);
            $display("test interrupt wake %0d done", i);
        end
        apb(1'b1, CFG, 32'h00000007);
        apb(1'b1, CTRL, 32'h0000000E);
        wt(0, 1'b1);
        repeat (2) @(posedge sys_clk);
        chk("p0float", 32'h00000000, port0_oe);
        fork
            u_src.pulse(2, 30);
            begin
                wt(5, 1'b1);
                chk("clks", 32'h00000001, cpu_clk_en & periph_clk_en & osc_enable);
                wt(4, 1'b1);
                @(posedge sys_clk);
                chk("vector", 32'h00000000, reset_vector);
                chk("ramfree", 32'h00000000, ram_block);
                chk("p14high", 32'hFFFFFFFF, port14_out);
            end
        join
        wt(4, 1'b0);
        rc("ctrlrst", CTRL, 32'h00000000);
        rc("cfgrst", CFG, 32'h00000000);
        $display("test reset wake done");
        stop_test;
    end

    // overall limit on run length
    initial begin
        repeat (50000) @(posedge sys_clk);
        $display("BAD run exp end got limit");
        miscompares++;
        stop_test;
    end
endmodule // power_down_entry_exit_control_tb_top

bind power_down_entry_exit_control sleep_chk u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ext_irq_line_a_n(ext_irq_line_a_n),
    .ext_irq_line_b_n(ext_irq_line_b_n), .ale_out(ale_out),
    .program_fetch_strobe(program_fetch_strobe), .osc_enable(osc_enable),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .core_reset(core_reset),
    .ram_block(ram_block), .wake_irq_req(wake_irq_req), .wake_irq_src(wake_irq_src),
    .reset_vector(reset_vector), .powerdown_active(powerdown_active));
